// file: rtl/scbm_core.sv
// Executes system control and block move instructions.
// Assumes operands and code in on-chip memory, one request per cycle.
module scbm_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction issue
  input wire logic issue_valid,
  input wire scbm_pkg::scbm_instr_t issue_instr,
  input wire logic adv_mode,
  output logic busy,
  output logic done,
  // Architectural state in
  input wire logic [31:0] pc_in,
  input wire logic [31:0] sp_in,
  input wire logic [31:0] ptr_in,
  input wire logic [31:0] src_in,
  input wire logic [31:0] dst_in,
  input wire logic [15:0] count_in,
  // Architectural state out
  output logic [31:0] pc_out,
  output logic [31:0] sp_out,
  output logic [31:0] ptr_out,
  output logic [31:0] src_out,
  output logic [31:0] dst_out,
  output logic [15:0] count_out,
  output logic [7:0] flag_register,
  output logic sleep_out,
  output logic [7:0] states_out,
  // Memory requests
  output logic mreq_valid,
  input wire logic mreq_ready,
  output scbm_pkg::scbm_mreq_t mreq,
  // Read return
  input wire logic rdata_valid,
  input wire logic [15:0] rdata
);
  typedef enum logic [5:0] {
    SCBM_S_IDLE = 6'b000001,
    SCBM_S_PUSH = 6'b000010,
    SCBM_S_READ = 6'b000100,
    SCBM_S_WAIT = 6'b001000,
    SCBM_S_WRITE = 6'b010000,
    SCBM_S_PAD = 6'b100000
  } scbm_state_t;

  scbm_state_t st_q, st_d;
  scbm_pkg::scbm_op_t op_q, op_d;
  logic [1:0] step_q, step_d;
  logic [1:0] vec_q, vec_d;
  logic [31:0] pc_q, pc_d, sp_q, sp_d, ptr_q, ptr_d;
  logic [31:0] src_q, src_d, dst_q, dst_d;
  logic [15:0] cnt_q, cnt_d, data_q, data_d;
  logic [23:0] disp_q, disp_d;
  logic [7:0] flag_q, flag_d, len_q, len_d;
  logic [23:0] target_q, target_d;
  logic done_q, done_d, sleep_q, sleep_d;
  logic push_v;
  scbm_pkg::scbm_mreq_t push_r;
  logic push_rdy, tload, thold;
  logic [23:0] tcount;
  logic out_v;

  // Bus waits stretch the instruction: only stalls that fill the buffer hold the count
  scbm_skid u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .in_data(push_r),
    .out_valid(out_v),
    .out_ready(mreq_ready),
    .out_data(mreq)
  );
  assign mreq_valid = out_v;

  scbm_timer u_tim (
    .clk(clk),
    .rst(rst),
    .load(tload),
    .target(target_q),
    .hold(thold),
    .count(tcount)
  );

  assign busy = st_q != SCBM_S_IDLE;
  assign done = done_q;
  assign pc_out = pc_q;
  assign sp_out = sp_q;
  assign ptr_out = ptr_q;
  assign src_out = src_q;
  assign dst_out = dst_q;
  assign count_out = cnt_q;
  assign flag_register = flag_q;
  assign sleep_out = sleep_q;
  assign states_out = target_q[7:0];

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    step_d = step_q;
    vec_d = vec_q;
    pc_d = pc_q;
    sp_d = sp_q;
    ptr_d = ptr_q;
    src_d = src_q;
    dst_d = dst_q;
    cnt_d = cnt_q;
    data_d = data_q;
    disp_d = disp_q;
    flag_d = flag_q;
    len_d = len_q;
    target_d = target_q;
    done_d = 1'b0;
    sleep_d = sleep_q;
    push_v = 1'b0;
    push_r = '0;
    tload = 1'b0;
    // bus waits: a full request buffer freezes the state count
    thold = !push_rdy;
    case (st_q)
      SCBM_S_IDLE: begin
        if (issue_valid) begin
          op_d = issue_instr.op;
          pc_d = pc_in;
          sp_d = sp_in;
          ptr_d = ptr_in;
          src_d = src_in;
          dst_d = dst_in;
          disp_d = issue_instr.disp;
          // Issue bus may change once taken
          vec_d = issue_instr.vec;
          step_d = 2'h0;
          tload = 1'b1;
          len_d = {4'h0, scbm_pkg::LEN_SHORT};
          target_d = {16'h0, scbm_pkg::ST_SHORT};
          st_d = SCBM_S_PAD;
          case (issue_instr.op)
            scbm_pkg::SCBM_OP_TRAP: begin
              target_d = {16'h0, adv_mode ? scbm_pkg::ST_TRAP_ADV
                                          : scbm_pkg::ST_TRAP_NORM};
              st_d = SCBM_S_PUSH;
            end
            scbm_pkg::SCBM_OP_ERET: begin
              target_d = {16'h0, scbm_pkg::ST_RTE};
              st_d = SCBM_S_READ;
            end
            scbm_pkg::SCBM_OP_LOAD_INC: begin
              target_d = {16'h0, scbm_pkg::ST_FLAG_MEM};
              st_d = SCBM_S_READ;
            end
            scbm_pkg::SCBM_OP_STORE_DEC: begin
              ptr_d = ptr_in - scbm_pkg::WORD_STEP;
              target_d = {16'h0, scbm_pkg::ST_FLAG_MEM};
              st_d = SCBM_S_WRITE;
            end
            scbm_pkg::SCBM_OP_STORE_D24: begin
              len_d = {4'h0, scbm_pkg::LEN_DISP24};
              target_d = {16'h0, scbm_pkg::ST_FLAG_MEM};
              st_d = SCBM_S_WRITE;
            end
            scbm_pkg::SCBM_OP_AND: begin
              flag_d = flag_q & issue_instr.imm;
            end
            scbm_pkg::SCBM_OP_OR: flag_d = flag_q | issue_instr.imm;
            scbm_pkg::SCBM_OP_XOR: flag_d = flag_q ^ issue_instr.imm;
            scbm_pkg::SCBM_OP_SLEEP: begin
              sleep_d = 1'b1;
            end
            scbm_pkg::SCBM_OP_MOVE_B, scbm_pkg::SCBM_OP_MOVE_W: begin
              cnt_d = issue_instr.op == scbm_pkg::SCBM_OP_MOVE_W ?
                      count_in : {8'h0, count_in[7:0]};
              len_d = {4'h0, scbm_pkg::LEN_MOVE};
              target_d = {16'h0, scbm_pkg::ST_MOVE_BASE} +
                         {6'h0, cnt_d, 2'h0};
              st_d = cnt_d == 16'h0 ? SCBM_S_PAD : SCBM_S_READ;
            end
            default: begin
            end
          endcase
        end
      end
      SCBM_S_PUSH: begin
        push_v = 1'b1;
        push_r.we = 1'b1;
        push_r.word = 1'b1;
        push_r.addr = sp_q - scbm_pkg::WORD_STEP;
        push_r.wdata = step_q == 2'h0 ? pc_q[15:0] : {8'h0, flag_q};
        if (push_rdy) begin
          sp_d = sp_q - scbm_pkg::WORD_STEP;
          step_d = step_q + 2'h1;
          if (step_q == 2'h1) begin
            st_d = SCBM_S_READ;
          end
        end
      end
      SCBM_S_READ: begin
        push_v = 1'b1;
        push_r.word = op_q != scbm_pkg::SCBM_OP_MOVE_B &&
                      op_q != scbm_pkg::SCBM_OP_MOVE_W;
        case (op_q)
          scbm_pkg::SCBM_OP_TRAP: push_r.addr = scbm_pkg::VEC_BASE +
            (adv_mode ? scbm_pkg::VEC_STEP_ADV : scbm_pkg::VEC_STEP_NORM) *
            {30'h0, vec_q};
          scbm_pkg::SCBM_OP_ERET: push_r.addr = sp_q;
          scbm_pkg::SCBM_OP_LOAD_INC: push_r.addr = ptr_q;
          default: push_r.addr = src_q;
        endcase
        if (push_rdy) begin
          st_d = SCBM_S_WAIT;
        end
      end
      SCBM_S_WAIT: begin
        if (rdata_valid) begin
          data_d = rdata;
          st_d = SCBM_S_PAD;
          case (op_q)
            scbm_pkg::SCBM_OP_TRAP: pc_d = {16'h0, rdata};
            scbm_pkg::SCBM_OP_ERET: begin
              sp_d = sp_q + scbm_pkg::WORD_STEP;
              if (step_q == 2'h0) begin
                flag_d = rdata[7:0];
                step_d = 2'h1;
                st_d = SCBM_S_READ;
              end else begin
                pc_d = {16'h0, rdata};
              end
            end
            scbm_pkg::SCBM_OP_LOAD_INC: begin
              flag_d = rdata[7:0];
              ptr_d = ptr_q + scbm_pkg::WORD_STEP;
            end
            default: st_d = SCBM_S_WRITE;
          endcase
        end
      end
      SCBM_S_WRITE: begin
        push_v = 1'b1;
        push_r.we = 1'b1;
        case (op_q)
          scbm_pkg::SCBM_OP_STORE_DEC: begin
            push_r.word = 1'b1;
            push_r.addr = ptr_q;
            push_r.wdata = {8'h0, flag_q};
          end
          scbm_pkg::SCBM_OP_STORE_D24: begin
            push_r.word = 1'b1;
            push_r.addr = ptr_q + {{8{disp_q[23]}}, disp_q};
            push_r.wdata = {8'h0, flag_q};
          end
          default: begin
            push_r.addr = dst_q;
            push_r.wdata = {8'h0, data_q[7:0]};
          end
        endcase
        if (push_rdy) begin
          st_d = SCBM_S_PAD;
          if (op_q == scbm_pkg::SCBM_OP_MOVE_B ||
              op_q == scbm_pkg::SCBM_OP_MOVE_W) begin
            src_d = src_q + scbm_pkg::BYTE_STEP;
            dst_d = dst_q + scbm_pkg::BYTE_STEP;
            cnt_d = cnt_q - 16'h1;
            st_d = cnt_d == 16'h0 ? SCBM_S_PAD : SCBM_S_READ;
          end
        end
      end
      SCBM_S_PAD: begin
        // Finish here: a separate end state would add a state
        if (tcount >= target_q) begin
          if (op_q != scbm_pkg::SCBM_OP_TRAP &&
              op_q != scbm_pkg::SCBM_OP_ERET) begin
            pc_d = pc_q + {24'h0, len_q};
          end
          done_d = 1'b1;
          st_d = SCBM_S_IDLE;
        end
      end
      default: st_d = SCBM_S_IDLE;
    endcase
    if (issue_valid && st_q == SCBM_S_IDLE) begin
      sleep_d = issue_instr.op == scbm_pkg::SCBM_OP_SLEEP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= SCBM_S_IDLE;
      op_q <= scbm_pkg::SCBM_OP_NOP;
      step_q <= 2'h0;
      vec_q <= 2'h0;
      pc_q <= 32'h0;
      sp_q <= 32'h0;
      ptr_q <= 32'h0;
      src_q <= 32'h0;
      dst_q <= 32'h0;
      cnt_q <= 16'h0;
      data_q <= 16'h0;
      disp_q <= 24'h0;
      flag_q <= scbm_pkg::FLAG_RST;
      len_q <= 8'h0;
      target_q <= 24'h0;
      done_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      step_q <= step_d;
      vec_q <= vec_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      ptr_q <= ptr_d;
      src_q <= src_d;
      dst_q <= dst_d;
      cnt_q <= cnt_d;
      data_q <= data_d;
      disp_q <= disp_d;
      flag_q <= flag_d;
      len_q <= len_d;
      target_q <= target_d;
      done_q <= done_d;
      sleep_q <= sleep_d;
    end
  end
endmodule

// file: rtl/scbm_pkg.sv
// Shared types and constants for the system control and block move unit.
// Assumes a single 200 MHz clock and one memory port shared by all ops.
package scbm_pkg;
  localparam logic [7:0] FLAG_RST = 8'h80;
  localparam logic [31:0] VEC_BASE = 32'h0000_0020;
  localparam logic [31:0] VEC_STEP_NORM = 32'h0000_0002;
  localparam logic [31:0] VEC_STEP_ADV = 32'h0000_0004;
  localparam logic [31:0] WORD_STEP = 32'h0000_0002;
  localparam logic [31:0] BYTE_STEP = 32'h0000_0001;
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [7:0] ST_TRAP_NORM = 8'h0e;
  localparam logic [7:0] ST_TRAP_ADV = 8'h10;
  localparam logic [7:0] ST_FLAG_MEM = 8'h08;
  localparam logic [7:0] ST_MOVE_BASE = 8'h08;
  localparam logic [7:0] ST_MOVE_PER = 8'h04;
  localparam logic [7:0] ST_SHORT = 8'h02;
  localparam logic [7:0] ST_RTE = 8'h0a;
  localparam logic [3:0] LEN_DISP24 = 4'ha;
  localparam logic [3:0] LEN_MOVE = 4'h4;
  localparam logic [3:0] LEN_SHORT = 4'h2;

  typedef enum logic [3:0] {
    SCBM_OP_NOP = 4'h0,
    SCBM_OP_SLEEP = 4'h1,
    SCBM_OP_TRAP = 4'h2,
    SCBM_OP_ERET = 4'h3,
    SCBM_OP_LOAD_INC = 4'h4,
    SCBM_OP_STORE_DEC = 4'h5,
    SCBM_OP_STORE_D24 = 4'h6,
    SCBM_OP_AND = 4'h7,
    SCBM_OP_OR = 4'h8,
    SCBM_OP_XOR = 4'h9,
    SCBM_OP_MOVE_B = 4'ha,
    SCBM_OP_MOVE_W = 4'hb
  } scbm_op_t;

  typedef struct packed {
    scbm_op_t op;
    logic [1:0] vec;
    logic [7:0] imm;
    logic [23:0] disp;
  } scbm_instr_t;

  typedef struct packed {
    logic we;
    logic word;
    logic [31:0] addr;
    logic [15:0] wdata;
  } scbm_mreq_t;
endpackage

// file: rtl/scbm_skid.sv
// Two-entry buffer for memory requests; a stall downstream loses nothing.
// Assumes both sides on clk; ready toward the source is registered.
module scbm_skid (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire scbm_pkg::scbm_mreq_t in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output scbm_pkg::scbm_mreq_t out_data
);
  scbm_pkg::scbm_mreq_t mem_q [2];
  scbm_pkg::scbm_mreq_t mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = cnt_q != 2'h2;
  assign out_valid = cnt_q != 2'h0;
  assign out_data = mem_q[rd_q];

  always_comb begin
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data;
    end
    wr_d = push ? ~wr_q : wr_q;
    rd_d = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end
endmodule

// file: rtl/scbm_timer.sv
// State counter that pads each instruction to its listed state count.
// Assumes the target arrives on clk no later than the cycle after load.
module scbm_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [23:0] target,
  input wire logic hold,
  // Status
  output logic [23:0] count
);
  logic [23:0] cnt_q, cnt_d;
  assign count = cnt_q;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = 24'h1;
    end else if (!hold && cnt_q != 24'h0 && cnt_q < target) begin
      cnt_d = cnt_q + 24'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 24'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: tb/scbm_core_properties.sv
// Checker for the system control and block move unit.
// Assumes only the core's ports; bound below the module.
module scbm_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Issue and status
  input wire logic issue_valid,
  input wire scbm_pkg::scbm_instr_t issue_instr,
  input wire logic adv_mode,
  input wire logic busy,
  input wire logic done,
  input wire logic [31:0] pc_in,
  input wire logic [31:0] ptr_in,
  // Results
  input wire logic [31:0] pc_out,
  input wire logic [31:0] ptr_out,
  input wire logic [7:0] flag_register,
  input wire logic sleep_out,
  input wire logic [7:0] states_out,
  // Memory requests
  input wire logic mreq_valid,
  input wire logic mreq_ready,
  input wire scbm_pkg::scbm_mreq_t mreq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  scbm_pkg::scbm_instr_t ins_q;
  logic [31:0] pc_q, ptr_q;
  logic [7:0] fl_q, cnt_q, cnt_d;
  assign take = issue_valid && !busy;
  // Saturates so long moves never wrap
  assign cnt_d = take ? 8'h00 : cnt_q + {7'h0, cnt_q != 8'hff};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ins_q <= '0;
      pc_q <= '0;
      ptr_q <= '0;
      fl_q <= '0;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (take) begin
        ins_q <= issue_instr;
        pc_q <= pc_in;
        ptr_q <= ptr_in;
        fl_q <= flag_register;
      end
    end
  end
  a_done_one_cycle: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_nop_pc_step: assert property (
    done && ins_q.op == scbm_pkg::SCBM_OP_NOP |-> pc_out == pc_q + 32'h2)
    else $error("no-op pc step wrong");
  a_short_exact: assert property (done && ins_q.op inside
    {scbm_pkg::SCBM_OP_NOP, scbm_pkg::SCBM_OP_SLEEP, scbm_pkg::SCBM_OP_AND,
    scbm_pkg::SCBM_OP_OR, scbm_pkg::SCBM_OP_XOR} |-> cnt_q == 8'h02)
    else $error("short op not two states");
  a_min_states: assert property (done |-> cnt_q >= states_out)
    else $error("done before listed states");
  a_trap_states: assert property (done &&
    ins_q.op == scbm_pkg::SCBM_OP_TRAP |-> states_out == (adv_mode ?
    8'h10 : 8'h0e)) else $error("trap state count wrong");
  a_flag_logic: assert property (done && ins_q.op inside
    {scbm_pkg::SCBM_OP_AND, scbm_pkg::SCBM_OP_OR, scbm_pkg::SCBM_OP_XOR}
    |-> flag_register == (ins_q.op == scbm_pkg::SCBM_OP_AND ?
    fl_q & ins_q.imm : ins_q.op == scbm_pkg::SCBM_OP_OR ?
    fl_q | ins_q.imm : fl_q ^ ins_q.imm)) else $error("flag logic wrong");
  a_store_keeps_flags: assert property (take && issue_instr.op inside
    {scbm_pkg::SCBM_OP_STORE_DEC, scbm_pkg::SCBM_OP_STORE_D24}
    |=> $stable(flag_register)[*6]) else $error("store changed flags");
  a_store_dec_addr: assert property (mreq_valid && mreq.we &&
    ins_q.op == scbm_pkg::SCBM_OP_STORE_DEC |-> mreq.addr == ptr_q - 32'h2)
    else $error("store address not pointer minus two");
  a_load_ptr_step: assert property (done &&
    ins_q.op == scbm_pkg::SCBM_OP_LOAD_INC |-> ptr_out == ptr_q + 32'h2)
    else $error("load pointer step wrong");
  a_sleep_entered: assert property (done &&
    ins_q.op == scbm_pkg::SCBM_OP_SLEEP |-> sleep_out)
    else $error("sleep not entered");
  a_mreq_held: assert property (mreq_valid && !mreq_ready
    |=> mreq_valid && $stable(mreq)) else $error("stalled request dropped");
  c_word_move: cover property (done && ins_q.op == scbm_pkg::SCBM_OP_MOVE_W);
  c_stall: cover property (mreq_valid && !mreq_ready);
  c_adv_trap: cover property (done && adv_mode &&
    ins_q.op == scbm_pkg::SCBM_OP_TRAP);
endmodule

bind scbm_core scbm_core_chk u_chk (.clk, .rst, .issue_valid, .issue_instr,
  .adv_mode, .busy, .done, .pc_in, .ptr_in, .pc_out, .ptr_out,
  .flag_register, .sleep_out, .states_out, .mreq_valid, .mreq_ready, .mreq);

// file: tb/scbm_mem.sv
// Zero-wait memory serving stack and operand requests.
// Assumes big-endian words; stall holds ready low.
module scbm_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests
  input wire logic mreq_valid,
  output logic mreq_ready,
  input wire scbm_pkg::scbm_mreq_t mreq,
  input wire logic stall,
  // Read return
  output logic rdata_valid,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [logic [31:0]];
  // Unwritten bytes read as a pattern: the low address byte xor 8'h5a
  function automatic logic [7:0] rd8(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5a;
  endfunction
  function automatic void wr8(input logic [31:0] a, input logic [7:0] d);
    mem[a] = d;
  endfunction
  assign mreq_ready = !stall;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_valid <= 1'b0;
      rdata <= 16'h0;
    end else begin
      rdata_valid <= 1'b0;
      // Released bus shows the last value inverted each cycle
      rdata <= ~rdata;
      if (mreq_valid && mreq_ready) begin
        if (mreq.we && mreq.word) begin
          wr8(mreq.addr, mreq.wdata[15:8]);
          wr8(mreq.addr + 32'h1, mreq.wdata[7:0]);
        end else if (mreq.we) begin
          wr8(mreq.addr, mreq.wdata[7:0]);
        end else begin
          rdata_valid <= 1'b1;
          rdata <= mreq.word ? {rd8(mreq.addr), rd8(mreq.addr + 32'h1)}
            : {2{rd8(mreq.addr)}};
        end
      end
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the system control and block move unit.
// Drives stall so the memory model beside it adds waits in the store and move tests.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, issue_valid = 1'b0, adv_mode = 1'b0;
  logic busy, done, sleep_out, mreq_valid, mreq_ready, rdata_valid;
  logic stall = 1'b0;
  scbm_pkg::scbm_instr_t issue_instr = '0;
  logic [31:0] pc_in = '0, sp_in = '0, ptr_in = '0, src_in = '0;
  logic [31:0] dst_in = '0, pc_out, sp_out, ptr_out, src_out, dst_out;
  logic [15:0] count_in = '0, count_out, rdata;
  logic [7:0] flag_register, states_out, fl = scbm_pkg::FLAG_RST;
  scbm_pkg::scbm_mreq_t mreq;
  int n_fail = 0, cmp_count = 0, cyc;
  always #2.5 clk = ~clk;
  scbm_core u_dut (.clk, .rst, .issue_valid, .issue_instr, .adv_mode, .busy,
    .done, .pc_in, .sp_in, .ptr_in, .src_in, .dst_in, .count_in, .pc_out,
    .sp_out, .ptr_out, .src_out, .dst_out, .count_out, .flag_register,
    .sleep_out, .states_out, .mreq_valid, .mreq_ready, .mreq, .rdata_valid,
    .rdata);
  scbm_mem u_mem (.clk, .rst, .mreq_valid, .mreq_ready, .mreq, .stall,
    .rdata_valid, .rdata);
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ge(input int got, input int lim);
    cmp_count++;
    if (got < lim) begin
      n_fail++;
      $display("[ERR] %0t got=%h min=%h", $time, got, lim);
    end
  endtask
  function automatic logic [15:0] w16(input logic [31:0] a);
    return {u_mem.rd8(a), u_mem.rd8(a + 32'h1)};
  endfunction
  // Called just after a rising edge; returns settled, mid-cycle
  task automatic go(input scbm_pkg::scbm_op_t op, input logic [7:0] im,
    input logic [23:0] ds);
    issue_valid <= 1'b1;
    issue_instr <= '{op, 2'h1, im, ds};
    @(posedge clk);
    issue_valid <= 1'b0;
    cyc = 0;
    @(negedge clk);
    while (done !== 1'b1 && cyc < 5000) begin
      @(negedge clk);
      cyc++;
    end
    if (cyc >= 5000) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic t_short();
    @(posedge clk);
    pc_in <= 32'h0001_fffe;
    go(scbm_pkg::SCBM_OP_NOP, 8'h00, 24'h0);
    chk(pc_out, 32'h0002_0000);
    chk(cyc, 2);
    @(posedge clk);
    go(scbm_pkg::SCBM_OP_SLEEP, 8'h00, 24'h0);
    chk(sleep_out, 1'b1);
    chk(cyc, 2);
  endtask
  task automatic t_logic();
    scbm_pkg::scbm_op_t ops [3] = '{scbm_pkg::SCBM_OP_AND,
      scbm_pkg::SCBM_OP_OR, scbm_pkg::SCBM_OP_XOR};
    logic [7:0] im [3] = '{8'h3c, 8'h41, 8'hff};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      go(ops[i], im[i], 24'h0);
      fl = i == 0 ? fl & im[i] : i == 1 ? fl | im[i] : fl ^ im[i];
      chk(flag_register, fl);
      chk(cyc, 2);
    end
  endtask
  task automatic t_trap(input logic adv);
    @(posedge clk);
    adv_mode <= adv;
    pc_in <= 32'h0000_4566;
    sp_in <= 32'h0000_ff00;
    go(scbm_pkg::SCBM_OP_TRAP, 8'h00, 24'h0);
    chk(w16(32'hfefe), 16'h4566);
    chk(u_mem.rd8(32'hfefd), fl);
    chk(sp_out, 32'hfefc);
    ge(cyc, adv ? 16 : 14);
    chk(pc_out, {16'h0, w16(adv ? 32'h24 : 32'h22)});
  endtask
  task automatic t_flags();
    @(posedge clk);
    u_mem.wr8(32'h800, 8'h2b);
    u_mem.wr8(32'h801, 8'h2b);
    sp_in <= 32'h800;
    go(scbm_pkg::SCBM_OP_ERET, 8'h00, 24'h0);
    fl = 8'h2b;
    chk(flag_register, fl);
    chk(pc_out[15:0], w16(32'h802));
    chk(sp_out, 32'h804);
    @(posedge clk);
    u_mem.wr8(32'h900, 8'hc5);
    u_mem.wr8(32'h901, 8'hc5);
    ptr_in <= 32'h900;
    go(scbm_pkg::SCBM_OP_LOAD_INC, 8'h00, 24'h0);
    fl = 8'hc5;
    chk(flag_register, fl);
    chk(ptr_out, 32'h902);
    ge(cyc, 8);
  endtask
  task automatic t_store();
    @(posedge clk);
    ptr_in <= 32'ha00;
    stall <= 1'b1;
    fork
      go(scbm_pkg::SCBM_OP_STORE_DEC, 8'h00, 24'h0);
      begin
        repeat (6) @(posedge clk);
        stall <= 1'b0;
      end
    join
    chk(u_mem.rd8(32'h9ff), fl);
    chk(ptr_out, 32'h9fe);
    ge(cyc, 8);
    @(posedge clk);
    ptr_in <= 32'hb00;
    // Negative offset proves the sign extension
    go(scbm_pkg::SCBM_OP_STORE_D24, 8'h00, 24'hfffff0);
    chk(u_mem.rd8(32'haf1), fl);
    chk(flag_register, fl);
  endtask
  task automatic t_move(input scbm_pkg::scbm_op_t op, input logic [15:0] n,
    input int m);
    @(posedge clk);
    src_in <= 32'h2000;
    dst_in <= 32'h3080;
    count_in <= n;
    stall <= 1'b1;
    fork
      go(op, 8'h00, 24'h0);
      begin
        repeat (10) @(posedge clk);
        stall <= 1'b0;
      end
    join
    for (int i = 0; i < m; i++) begin
      chk(u_mem.rd8(32'h3080 + i), 8'(i) ^ 8'h5a);
    end
    chk(u_mem.rd8(32'h3080 + m), 8'(8'h80 + m) ^ 8'h5a);
    chk(src_out, 32'h2000 + m);
    chk(dst_out, 32'h3080 + m);
    chk(count_out[7:0], 8'h00);
    ge(cyc, 8 + 4 * m);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_short();
    t_logic();
    t_trap(1'b0);
    t_trap(1'b1);
    t_flags();
    t_store();
    t_move(scbm_pkg::SCBM_OP_MOVE_B, 16'h0000, 0);
    t_move(scbm_pkg::SCBM_OP_MOVE_B, 16'h0102, 2);
    t_move(scbm_pkg::SCBM_OP_MOVE_W, 16'h0103, 259);
    summarize();
  end
endmodule
